// ### hw/swn_pkg.sv
// Constants, types and timing figures shared by the single-wire node files.
// Overview of operation
// - Every datagram carries an eight-bit check value, polynomial feedback constant 0x07.
// - Check starts at zero, bytes enter LSB first, sync nibble taken as correct.
// - Per bit: if bit 7 XOR data is one, shift left and XOR 0x07.
// - The check byte is last and covers all preceding datagram bytes.
// - Act only on datagrams that pass the check and carry our node number.
// - Increment the datagram counter for each correctly received write datagram.
// - Node number bit 0 from low select pin, bit 1 from high select pin.
// - One non-inverted two-way pin carries both receive and transmit data.
// - Watch the pin continuously and take bit timing from each sync nibble.
// - On a valid read, enable the driver and reply at the request's rate.
// - Release the driver four bit times after the last reply stop bit.
// - Write register addresses have bit 7 set; reads use the plain address.
// - All registers are zero after power-up unless noted otherwise.
// - Writing one to a status flag bit clears it; reads report flags.
// - Bit time is measured from start-bit fall to the sync bit 2-3 fall.
// - A read reply carries the all-ones address code instead of a node number.
// - Reply waits a programmable delay in multiples of eight bit times.
// - Gap over 63 bit times resets reception; restart needs 12 idle bit times.
package swn_pkg;

    localparam logic [7:0]  CRC_POLY       = 8'h07;
    localparam logic [7:0]  SYNC_BYTE      = 8'h05;
    localparam logic [3:0]  SYNC_NIBBLE    = 4'h5;
    localparam logic [7:0]  REPLY_ADDR     = 8'hff;
    localparam int          WRITE_FLAG_BIT = 7;
    localparam logic [2:0]  READ_LAST_IDX  = 3'h3;
    localparam logic [2:0]  WRITE_LAST_IDX = 3'h7;
    localparam logic [2:0]  REPLY_LAST_IDX = 3'h7;
    localparam logic [6:0]  STATUS_ADDR    = 7'h01;
    localparam logic [6:0]  COUNT_ADDR     = 7'h02;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;

    localparam int          CLK_HZ         = 10_000_000;
    localparam int          GLITCH_CLKS    = 16;
    localparam logic [6:0]  GAP_LIMIT_BITS = 7'd63;
    localparam logic [3:0]  IDLE_BITS      = 4'd12;
    localparam logic [2:0]  HOLD_BITS      = 3'd4;
    localparam int          SYNC_SPAN_BITS = 4;
    localparam logic [3:0]  STOP_IDX       = 4'd9;
    localparam logic [3:0]  FRAME_LAST     = 4'd9;

    typedef enum logic [2:0] {
        SWN_R_HUNT = 3'b000,
        SWN_R_SYNC = 3'b001,
        SWN_R_BITS = 3'b010,
        SWN_R_GAP  = 3'b011,
        SWN_R_ERR  = 3'b100,
        SWN_R_BUSY = 3'b101
    } swn_rx_state_t;

    typedef enum logic [1:0] {
        SWN_T_IDLE = 2'b00,
        SWN_T_WAIT = 2'b01,
        SWN_T_BYTE = 2'b10,
        SWN_T_HOLD = 2'b11
    } swn_tx_state_t;

endpackage

// ### hw/swn_crc8.sv
// Byte-wide check value accumulator, bits taken least significant first.
`timescale 1ns/1ps
module swn_crc8 (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_clr,
    input  wire logic       i_en,
    input  wire logic [7:0] i_byte,
    output logic      [7:0] o_crc
);

    function automatic logic [7:0] crc_step(input logic [7:0] crc_in, input logic [7:0] data);
        logic [7:0] c;
        c = crc_in;
        for (int j = 0; j < 8; j++)
        begin
            if (c[7] ^ data[j])
                c = {c[6:0], 1'b0} ^ swn_pkg::CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_crc <= 8'h00;
        else if (i_clr)
            o_crc <= 8'h00;
        else if (i_en)
            o_crc <= crc_step(o_crc, i_byte);
    end

endmodule // swn_crc8

// ### hw/swn_node.sv
// Single-wire node: sync-locked receiver, datagram checker and read reply sender.
`timescale 1ns/1ps
module swn_node #(
    parameter int STATUS_BITS = 3,
    parameter int MEAS_W      = 16
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_line_in,
    output logic                        o_line_out,
    output logic                        o_line_oe,
    input  wire logic                   i_node_select_pin_low,
    input  wire logic                   i_node_select_pin_high,
    input  wire logic [3:0]             i_reply_wait_setting,
    input  wire logic [STATUS_BITS-1:0] i_status_set,
    input  wire logic [31:0]            i_rd_data,
    output logic                        o_wr_valid,
    output logic [6:0]                  o_wr_addr,
    output logic [31:0]                 o_wr_data,
    output logic                        o_rd_valid,
    output logic [6:0]                  o_rd_addr,
    output logic [7:0]                  o_dgram_count,
    output logic [STATUS_BITS-1:0]      o_status_flags
);

    swn_pkg::swn_rx_state_t rx_state_r;
    swn_pkg::swn_tx_state_t tx_state_r;
    logic [MEAS_W-1:0] baud_cnt_r;
    logic [MEAS_W-1:0] bit_time_r;
    logic [MEAS_W-1:0] meas_r;
    logic              falls_r;
    logic              line_prev_r;
    logic [3:0]        bit_idx_r;
    logic [7:0]        shift_r;
    logic [6:0]        gap_r;
    logic [3:0]        idle_r;
    logic [2:0]        byte_idx_r;
    logic [7:0]        node_r;
    logic [7:0]        reg_r;
    logic [31:0]       data_r;
    logic [6:0]        wait_r;
    logic [2:0]        tx_idx_r;
    logic [3:0]        tx_bit_r;
    logic [8:0]        tx_frame_r;
    logic [31:0]       tx_data_r;
    logic [2:0]        hold_r;
    logic              tx_done_r;

    logic              fall;
    logic              tick;
    logic              reload_half;
    logic              stop_seen;
    logic              stop_ok;
    logic              last_byte;
    logic              crc_good;
    logic              addr_match;
    logic              accept;
    logic              is_write;
    logic [7:0]        rx_crc;
    logic [7:0]        tx_crc;
    logic [1:0]        node_number;
    logic [MEAS_W-1:0] bit_meas;
    logic [6:0]        wait_target;
    logic              tx_load;
    logic              tx_first;
    logic [7:0]        tx_byte;
    logic [31:0]       reply_word;

    assign node_number = {i_node_select_pin_high, i_node_select_pin_low};
    assign fall        = line_prev_r & ~i_line_in;
    assign tick        = (baud_cnt_r == '0) && (rx_state_r != swn_pkg::SWN_R_SYNC);
    assign bit_meas    = (meas_r + MEAS_W'(1)) >> 2;

    // Datagram decisions are made on the cycle that samples each stop bit.
    assign stop_seen  = (rx_state_r == swn_pkg::SWN_R_BITS) && tick && (bit_idx_r == swn_pkg::STOP_IDX);
    assign stop_ok    = stop_seen && i_line_in;
    assign is_write   = reg_r[swn_pkg::WRITE_FLAG_BIT];
    assign last_byte  = is_write ? (byte_idx_r == swn_pkg::WRITE_LAST_IDX)
                                 : (byte_idx_r == swn_pkg::READ_LAST_IDX);
    assign crc_good   = (rx_crc == shift_r);
    assign addr_match = (node_r == {6'h00, node_number});
    assign accept     = stop_ok && last_byte && crc_good && addr_match;
    assign reload_half = ((rx_state_r == swn_pkg::SWN_R_SYNC) && fall && falls_r)
                       || ((rx_state_r == swn_pkg::SWN_R_GAP) && fall);

    swn_crc8 u_rx_crc (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_clr  (rx_state_r == swn_pkg::SWN_R_HUNT),
        .i_en   (stop_ok && !last_byte),
        .i_byte (shift_r),
        .o_crc  (rx_crc)
    );

    // The bit clock enable: reloaded to half a bit at the sync bit 2-3 fall and at each later start edge for centre sampling.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            baud_cnt_r <= '0;
        else if (reload_half)
            baud_cnt_r <= (rx_state_r == swn_pkg::SWN_R_SYNC) ? bit_meas >> 1 : bit_time_r >> 1;
        else if ((rx_state_r == swn_pkg::SWN_R_SYNC) && fall && !falls_r)
            baud_cnt_r <= baud_cnt_r;
        else if (baud_cnt_r == '0)
            baud_cnt_r <= bit_time_r - MEAS_W'(1);
        else
            baud_cnt_r <= baud_cnt_r - MEAS_W'(1);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            line_prev_r <= 1'b1;
        else
            line_prev_r <= i_line_in;
    end

    // Receiver sequencing: sync measurement, byte sampling, gap and error recovery.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rx_state_r <= swn_pkg::SWN_R_HUNT;
            meas_r     <= '0;
            falls_r    <= 1'b0;
            bit_time_r <= MEAS_W'(swn_pkg::GLITCH_CLKS);
            bit_idx_r  <= 4'h0;
            shift_r    <= 8'h00;
            gap_r      <= 7'h00;
            idle_r     <= 4'h0;
            byte_idx_r <= 3'h0;
            node_r     <= 8'h00;
            reg_r      <= 8'h00;
            data_r     <= 32'h0000_0000;
        end
        else
        begin
            case (rx_state_r)
                swn_pkg::SWN_R_HUNT:
                begin
                    byte_idx_r <= 3'h0;
                    reg_r      <= 8'h00;
                    if (fall)
                    begin
                        rx_state_r <= swn_pkg::SWN_R_SYNC;
                        meas_r     <= '0;
                        falls_r    <= 1'b0;
                    end
                end
                swn_pkg::SWN_R_SYNC:
                begin
                    meas_r <= meas_r + MEAS_W'(1);
                    if (&meas_r)
                        rx_state_r <= swn_pkg::SWN_R_ERR;
                    else if (fall && !falls_r)
                        falls_r <= 1'b1;
                    else if (fall)
                    begin
                        if (bit_meas < MEAS_W'(swn_pkg::GLITCH_CLKS))
                            rx_state_r <= swn_pkg::SWN_R_ERR;
                        else
                        begin
                            bit_time_r <= bit_meas;
                            rx_state_r <= swn_pkg::SWN_R_BITS;
                            bit_idx_r  <= 4'd4;
                            shift_r    <= {4'h0, swn_pkg::SYNC_NIBBLE};
                            gap_r      <= 7'd4;
                        end
                    end
                end
                swn_pkg::SWN_R_BITS:
                begin
                    if (tick)
                    begin
                        gap_r <= gap_r + 7'd1;
                        if (bit_idx_r == 4'h0 && i_line_in)
                            rx_state_r <= swn_pkg::SWN_R_ERR;
                        else if (bit_idx_r != 4'h0 && bit_idx_r != swn_pkg::STOP_IDX)
                            shift_r[bit_idx_r[2:0] - 3'd1] <= i_line_in;
                        bit_idx_r <= bit_idx_r + 4'd1;
                    end
                    if (stop_seen)
                    begin
                        bit_idx_r  <= 4'h0;
                        byte_idx_r <= byte_idx_r + 3'd1;
                        if (byte_idx_r == 3'd1)
                            node_r <= shift_r;
                        if (byte_idx_r == 3'd2)
                            reg_r <= shift_r;
                        if (byte_idx_r >= 3'd3 && !last_byte)
                            data_r <= {data_r[23:0], shift_r};
                        if (!stop_ok || (last_byte && !crc_good))
                            rx_state_r <= swn_pkg::SWN_R_ERR;
                        else if (accept && !is_write)
                            rx_state_r <= swn_pkg::SWN_R_BUSY;
                        else if (last_byte)
                            rx_state_r <= swn_pkg::SWN_R_HUNT;
                        else
                            rx_state_r <= swn_pkg::SWN_R_GAP;
                    end
                end
                swn_pkg::SWN_R_GAP:
                begin
                    if (fall)
                    begin
                        rx_state_r <= swn_pkg::SWN_R_BITS;
                        gap_r      <= 7'h00;
                    end
                    else if (tick)
                    begin
                        gap_r <= gap_r + 7'd1;
                        if (gap_r >= swn_pkg::GAP_LIMIT_BITS)
                            rx_state_r <= swn_pkg::SWN_R_HUNT;
                    end
                end
                swn_pkg::SWN_R_ERR:
                begin
                    if (!i_line_in)
                        idle_r <= 4'h0;
                    else if (tick)
                    begin
                        idle_r <= idle_r + 4'd1;
                        if (idle_r + 4'd1 >= swn_pkg::IDLE_BITS)
                        begin
                            idle_r     <= 4'h0;
                            rx_state_r <= swn_pkg::SWN_R_HUNT;
                        end
                    end
                end
                swn_pkg::SWN_R_BUSY:
                begin
                    if (tx_done_r)
                        rx_state_r <= swn_pkg::SWN_R_HUNT;
                end
                default:
                    rx_state_r <= swn_pkg::SWN_R_HUNT;
            endcase
        end
    end

    // Write strobe to the register side, only for accepted write datagrams.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_wr_valid <= 1'b0;
            o_wr_addr  <= 7'h00;
            o_wr_data  <= 32'h0000_0000;
        end
        else
        begin
            o_wr_valid <= accept && is_write;
            if (accept && is_write)
            begin
                o_wr_addr <= reg_r[6:0];
                o_wr_data <= data_r;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_dgram_count <= swn_pkg::COUNT_RESET;
        else if (accept && is_write)
            o_dgram_count <= o_dgram_count + 8'd1;
    end

    // Sticky status flags; a new event wins over a clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_status_flags <= '0;
        else if (accept && is_write && reg_r[6:0] == swn_pkg::STATUS_ADDR)
            o_status_flags <= (o_status_flags & ~data_r[STATUS_BITS-1:0]) | i_status_set;
        else
            o_status_flags <= o_status_flags | i_status_set;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rd_valid <= 1'b0;
            o_rd_addr  <= 7'h00;
        end
        else
        begin
            o_rd_valid <= accept && !is_write;
            if (accept && !is_write)
                o_rd_addr <= reg_r[6:0];
        end
    end

    // Reply transmitter.
    assign wait_target = {i_reply_wait_setting[3:1], 1'b1, 3'b000};
    assign tx_first    = (tx_state_r == swn_pkg::SWN_T_WAIT) && tick && (wait_r + 7'd1 >= wait_target);
    assign tx_load     = tx_first
                       || ((tx_state_r == swn_pkg::SWN_T_BYTE) && tick && (tx_bit_r == swn_pkg::FRAME_LAST)
                           && (tx_idx_r != swn_pkg::REPLY_LAST_IDX));
    assign reply_word  = (o_rd_addr == swn_pkg::STATUS_ADDR) ? 32'(o_status_flags)
                       : (o_rd_addr == swn_pkg::COUNT_ADDR)  ? {24'h000000, o_dgram_count}
                       : i_rd_data;

    always_comb
    begin
        case (tx_first ? 3'h0 : tx_idx_r + 3'd1)
            3'h0:    tx_byte = swn_pkg::SYNC_BYTE;
            3'h1:    tx_byte = swn_pkg::REPLY_ADDR;
            3'h2:    tx_byte = {1'b0, o_rd_addr};
            3'h3:    tx_byte = tx_data_r[31:24];
            3'h4:    tx_byte = tx_data_r[23:16];
            3'h5:    tx_byte = tx_data_r[15:8];
            3'h6:    tx_byte = tx_data_r[7:0];
            default: tx_byte = tx_crc;
        endcase
    end

    swn_crc8 u_tx_crc (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_clr  (tx_state_r == swn_pkg::SWN_T_IDLE),
        .i_en   (tx_load && (tx_first || tx_idx_r + 3'd1 != swn_pkg::REPLY_LAST_IDX)),
        .i_byte (tx_byte),
        .o_crc  (tx_crc)
    );

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_state_r <= swn_pkg::SWN_T_IDLE;
            wait_r     <= 7'h00;
            tx_idx_r   <= 3'h0;
            tx_bit_r   <= 4'h0;
            tx_frame_r <= 9'h1ff;
            tx_data_r  <= 32'h0000_0000;
            hold_r     <= 3'h0;
            tx_done_r  <= 1'b0;
            o_line_out <= 1'b1;
            o_line_oe  <= 1'b0;
        end
        else
        begin
            tx_done_r <= 1'b0;
            if (tx_load)
            begin
                tx_idx_r   <= tx_first ? 3'h0 : tx_idx_r + 3'd1;
                tx_bit_r   <= 4'h0;
                tx_frame_r <= {1'b1, tx_byte};
                o_line_out <= 1'b0;
                o_line_oe  <= 1'b1;
            end
            case (tx_state_r)
                swn_pkg::SWN_T_IDLE:
                begin
                    wait_r <= 7'h00;
                    if (o_rd_valid)
                        tx_state_r <= swn_pkg::SWN_T_WAIT;
                end
                swn_pkg::SWN_T_WAIT:
                begin
                    if (tick)
                        wait_r <= wait_r + 7'd1;
                    if (tx_first)
                    begin
                        tx_data_r  <= reply_word;
                        tx_state_r <= swn_pkg::SWN_T_BYTE;
                    end
                end
                swn_pkg::SWN_T_BYTE:
                begin
                    if (tick && tx_bit_r != swn_pkg::FRAME_LAST)
                    begin
                        o_line_out <= tx_frame_r[0];
                        tx_frame_r <= {1'b1, tx_frame_r[8:1]};
                        tx_bit_r   <= tx_bit_r + 4'd1;
                    end
                    else if (tick && tx_idx_r == swn_pkg::REPLY_LAST_IDX)
                    begin
                        hold_r     <= 3'h1;
                        tx_state_r <= swn_pkg::SWN_T_HOLD;
                    end
                end
                swn_pkg::SWN_T_HOLD:
                begin
                    if (tick)
                    begin
                        hold_r <= hold_r + 3'd1;
                        if (hold_r == swn_pkg::HOLD_BITS)
                        begin
                            o_line_oe  <= 1'b0;
                            tx_done_r  <= 1'b1;
                            tx_state_r <= swn_pkg::SWN_T_IDLE;
                        end
                    end
                end
                default:
                    tx_state_r <= swn_pkg::SWN_T_IDLE;
            endcase
        end
    end

endmodule // swn_node

// ### tb/swn_node_chk.sv
// Port-level assertions for the single-wire node.
`timescale 1ns/1ps
module swn_node_chk #(parameter int STATUS_BITS = 3) (
    input wire logic                   i_clk,
    input wire logic                   i_rstn,
    input wire logic [STATUS_BITS-1:0] i_status_set,
    input wire logic                   o_line_out,
    input wire logic                   o_line_oe,
    input wire logic                   o_wr_valid,
    input wire logic                   o_rd_valid,
    input wire logic [7:0]             o_dgram_count,
    input wire logic [STATUS_BITS-1:0] o_status_flags
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_cnt_inc; o_wr_valid |-> o_dgram_count == $past(o_dgram_count) + 8'h01; endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("count did not step");
    property p_cnt_hold; !o_wr_valid |-> $stable(o_dgram_count); endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved alone");
    property p_wr_pulse; o_wr_valid |=> !o_wr_valid; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_rd_quiet; o_rd_valid |=> !o_line_oe [*8]; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("reply too early");
    property p_start; $rose(o_line_oe) |-> !o_line_out; endproperty
    a_start: assert property (p_start) else $error("reply lacks start bit");
    property p_idle; !o_line_oe |-> o_line_out; endproperty
    a_idle: assert property (p_idle) else $error("idle output low");
    property p_hold; $fell(o_line_oe) |-> $past(o_line_out) && $past(o_line_out, 16); endproperty
    a_hold: assert property (p_hold) else $error("release not after high hold");
    property p_flag; |i_status_set |=> (o_status_flags & $past(i_status_set)) == $past(i_status_set); endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    c_wr: cover property (o_wr_valid);
    c_rd: cover property (o_rd_valid);
    c_rel: cover property ($fell(o_line_oe));
endmodule // swn_node_chk

bind swn_node swn_node_chk #(.STATUS_BITS(STATUS_BITS)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_status_set(i_status_set), .o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_wr_valid(o_wr_valid),
    .o_rd_valid(o_rd_valid), .o_dgram_count(o_dgram_count), .o_status_flags(o_status_flags));

// ### tb/swn_host.sv
// Host UART model that sends datagrams and reads node replies.
`timescale 1ns/1ps
module swn_host #(parameter int T = 20) (
    input  wire logic i_clk,
    input  wire logic i_line,
    output logic      o_buf_n,
    output logic      o_val
);
    initial o_buf_n = 1'b1;
    initial o_val = 1'b1;
    function automatic logic [7:0] crc8(input logic [7:0] b [8], input int n);
        logic [7:0] c;
        logic [7:0] d;
        c = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            d = b[i];
            for (int j = 0; j < 8; j++)
            begin
                c = (c[7] ^ d[0]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
                d = d >> 1;
            end
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] b [8], input int n, input logic [7:0] flip);
        logic [9:0] f;
        b[n-1] = crc8(b, n - 1) ^ flip;
        @(posedge i_clk);
        o_buf_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            f = {1'b1, b[i], 1'b0};
            for (int k = 0; k < 10; k++)
            begin
                o_val <= f[k];
                repeat (T) @(posedge i_clk);
            end
        end
        o_buf_n <= 1'b1;
    endtask
    // Receiving starts only after sending ends, so the own echo is never taken as reply.
    // Sampling on the falling clock edge keeps clear of the node's output updates.
    task automatic recv(output logic [7:0] r [8], output logic ok, output int lat);
        int w;
        ok = 1'b1;
        lat = 0;
        for (int i = 0; i < 8; i++)
        begin
            w = 0;
            while (i_line !== 1'b0 && w < 4000)
            begin
                @(negedge i_clk);
                w++;
            end
            if (i == 0) lat = w;
            repeat (T / 2) @(negedge i_clk);
            if (w >= 4000 || i_line !== 1'b0) ok = 1'b0;
            for (int k = 0; k < 8; k++)
            begin
                repeat (T) @(negedge i_clk);
                r[i][k] = i_line;
            end
            repeat (T) @(negedge i_clk);
            if (i_line !== 1'b1) ok = 1'b0;
        end
    endtask
endmodule // swn_host

// ### tb/tb_top.sv
// Self-checking bench for the single-wire node.
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0, i_rstn = 1'b0, lo = 1'b0, hi = 1'b1, sel = 1'b0, h_buf_n, h_val, oe, lout, wv, rv;
    logic [2:0] st_set = 3'h0, flags;
    logic [3:0] dly = 4'h3;
    logic [6:0] wa, ra, rd_a;
    logic [7:0] cnt;
    logic [31:0] wd;
    logic [7:0] wr_a;
    logic [31:0] wr_d;
    int n_fail = 0, checked = 0, n_wr = 0, cyc = 0, ecnt = 0;
    wire line = oe ? lout : ((sel && !h_buf_n) ? h_val : 1'b1);
    always #50 i_clk = ~i_clk;
    swn_node u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_line_in(line), .o_line_out(lout), .o_line_oe(oe),
        .i_node_select_pin_low(lo), .i_node_select_pin_high(hi), .i_reply_wait_setting(dly),
        .i_status_set(st_set), .i_rd_data(32'h0000_00a5), .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd),
        .o_rd_valid(rv), .o_rd_addr(ra), .o_dgram_count(cnt), .o_status_flags(flags));
    swn_host #(.T(20)) u_host (.i_clk(i_clk), .i_line(line), .o_buf_n(h_buf_n), .o_val(h_val));
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (wv)
        begin
            n_wr <= n_wr + 1;
            wr_a <= {1'b0, wa};
            wr_d <= wd;
        end
        if (rv)
            rd_a <= ra;
        if (cyc == 60000)
        begin
            n_fail++;
            $display("mismatch %0t timeout", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic t_write(input logic [1:0] nd, input logic [7:0] rg, input logic [31:0] d,
                           input logic [7:0] flip, input int ok);
        logic [7:0] b [8];
        int n0;
        b = '{8'h05, {6'h0, nd}, rg, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
        n0 = n_wr;
        u_host.send(b, 8, flip);
        repeat (300) @(posedge i_clk);
        ecnt = ecnt + ok;
        chk(n_wr - n0, ok, "write accepted");
        chk(cnt, ecnt[7:0], "datagram count");
        if (ok) chk(wr_a, rg & 8'h7f, "write address");
        if (ok) chk(wr_d, d, "write data");
        $display("test write to node %0d done", nd);
    endtask
    task automatic t_read(input logic [7:0] rg, input logic [31:0] d, input logic [3:0] w);
        logic [7:0] b [8];
        logic [7:0] r [8];
        logic [7:0] e [8];
        logic ok;
        int lat;
        b = '{8'h05, 8'h02, rg, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        e = '{8'h05, 8'hff, rg, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
        e[7] = u_host.crc8(e, 7);
        dly <= w;
        u_host.send(b, 4, 8'h00);
        u_host.recv(r, ok, lat);
        chk(ok, 1'b1, "reply framing");
        chk(rd_a, rg, "read address");
        chk(lat >= ((w | 4'h1) * 8 - 1) * 20 && lat <= ((w | 4'h1) * 8 + 1) * 20, 1'b1, "reply delay");
        for (int i = 0; i < 8; i++) chk(r[i], e[i], "reply byte");
        repeat (2) @(posedge i_clk);
        chk(oe, 1'b1, "driver held");
        repeat (120) @(posedge i_clk);
        chk(oe, 1'b0, "driver released");
        $display("test read of %h done", rg);
    endtask
    task automatic t_status;
        st_set <= 3'h3;
        @(posedge i_clk);
        st_set <= 3'h0;
        t_write(2'h2, 8'h81, 32'h1, 8'h00, 1);
        chk(flags, 3'h2, "flags after clear");
        $display("test status done");
    endtask
    task automatic t_reset;
        sel <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(cnt, 8'h00, "count at reset");
        chk(oe, 1'b0, "driver at reset");
        $display("test reset done");
    endtask
    task automatic t_pins;
        lo <= 1'b1;
        hi <= 1'b0;
        t_write(2'h1, 8'h93, 32'h0bad_cafe, 8'h00, 1);
        lo <= 1'b0;
        hi <= 1'b1;
        $display("test pins done");
    endtask
    task automatic end_sim;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
        t_write(2'h2, 8'h90, 32'h1234_5678, 8'h00, 1);
        t_write(2'h2, 8'h90, 32'h1234_5678, 8'h01, 0);
        t_write(2'h1, 8'h90, 32'h1234_5678, 8'h00, 0);
        t_pins();
        t_status();
        t_read(8'h02, {24'h0, ecnt[7:0]}, 4'h3);
        t_read(8'h10, 32'h0000_00a5, 4'h0);
        t_read(8'h01, 32'h2, 4'h3);
        end_sim();
    end
endmodule // tb_top
